// *** core/bss_averager.sv ***
`timescale 1ns/1ps
`default_nettype none
module bss_averager (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	// Sample stream
	input  wire logic                        clear,
	input  wire logic                        sampleValid,
	input  wire logic [bss_pkg::WORD_W-1:0]  sample,
	// Mean and window-full flag
	output logic      [bss_pkg::WORD_W-1:0]  mean,
	output logic                             full
);
	logic [bss_pkg::WORD_W-1:0] win [bss_pkg::AVG_DEPTH];
	logic [bss_pkg::AVG_LOG2-1:0] wrPtr_reg;
	logic [bss_pkg::AVG_LOG2:0]   count_reg;
	logic signed [bss_pkg::SUM_W-1:0] sum_reg;
	logic signed [bss_pkg::SUM_W-1:0] sum_next;
	logic signed [bss_pkg::SUM_W-1:0] inExt;
	logic signed [bss_pkg::SUM_W-1:0] outExt;
	logic [bss_pkg::WORD_W-1:0] mean_reg;

	assign inExt    = bss_pkg::SUM_W'(signed'(sample));
	assign outExt   = bss_pkg::SUM_W'(signed'(win[wrPtr_reg]));
	assign sum_next = sum_reg + inExt - outExt;
	assign mean     = mean_reg;
	assign full     = count_reg[bss_pkg::AVG_LOG2];

	// ==========================================
	// Window store, zero-filled before use
	genvar g;
	generate
		for (g = 0; g < bss_pkg::AVG_DEPTH; g++) begin : gWin
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n)
					win[g] <= bss_pkg::ZERO_WORD;
				else if (clear)
					win[g] <= bss_pkg::ZERO_WORD;
				else if (sampleValid && wrPtr_reg == bss_pkg::AVG_LOG2'(g))
					win[g] <= sample;
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_reg <= '0;
			count_reg <= '0;
			sum_reg   <= '0;
			mean_reg  <= bss_pkg::ZERO_WORD;
		end else if (clear) begin
			wrPtr_reg <= '0;
			count_reg <= '0;
			sum_reg   <= '0;
			mean_reg  <= bss_pkg::ZERO_WORD;
		end else if (sampleValid) begin
			wrPtr_reg <= wrPtr_reg + 1'b1;
			if (!full)
				count_reg <= count_reg + 1'b1;
			sum_reg   <= sum_next;
			mean_reg  <= bss_pkg::WORD_W'(sum_next >>> bss_pkg::AVG_LOG2);
		end
	end
endmodule
`default_nettype wire

// *** core/bss_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module bss_core #(
	parameter int EXTRA_CYCLES  = bss_pkg::EXTRA_CYCLES,
	parameter int SETTLE_CYCLES = bss_pkg::SETTLE_CYCLES
) (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	// Host bus side, same clock
	input  wire logic                        remoteReq,
	input  wire logic                        localReq,
	input  wire logic                        voltWr,
	input  wire logic                        currWr,
	input  wire logic                        outWr,
	input  wire logic                        outOnIn,
	input  wire logic [bss_pkg::WORD_W-1:0]  setData,
	// Supply programming
	output logic                             remoteMode,
	output logic      [bss_pkg::WORD_W-1:0]  voltProg,
	output logic      [bss_pkg::WORD_W-1:0]  currProg,
	output logic                             outputOn,
	// Measurement
	input  wire logic                        sampleValid,
	input  wire logic [bss_pkg::WORD_W-1:0]  sample,
	output logic      [bss_pkg::WORD_W-1:0]  readback,
	output logic                             readbackValid
);
	logic remote_reg;
	logic outOn_reg;
	logic [bss_pkg::WORD_W-1:0] volt_reg;
	logic [bss_pkg::WORD_W-1:0] curr_reg;
	bss_pkg::bss_rb_state_t state_reg;
	bss_pkg::bss_rb_state_t state_next;
	logic [31:0] timer_reg;
	logic [31:0] timer_next;
	logic        avgFull;
	logic        hostWr;

	// ==========================================
	// Setpoints and mode
	assign hostWr     = remote_reg;
	assign remoteMode = remote_reg;
	assign voltProg   = volt_reg;
	assign currProg   = curr_reg;
	assign outputOn   = outOn_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			remote_reg <= 1'b0;
			volt_reg   <= bss_pkg::ZERO_WORD;
			curr_reg   <= bss_pkg::ZERO_WORD;
			outOn_reg  <= 1'b0;
		end else begin
			if (localReq)
				remote_reg <= 1'b0;
			else if (remoteReq)
				remote_reg <= 1'b1;
			if (hostWr && voltWr)
				volt_reg <= setData;
			if (hostWr && currWr)
				curr_reg <= setData;
			if (hostWr && outWr)
				outOn_reg <= outOnIn;
		end
	end

	// ==========================================
	// Readback averaging
	bss_averager uAvg (
		.clk         (clk),
		.rst_n       (rst_n),
		.clear       (1'b0),
		.sampleValid (sampleValid),
		.sample      (sample),
		.mean        (readback),
		.full        (avgFull)
	);

	// ==========================================
	// Validity timing
	always_comb begin
		state_next = state_reg;
		timer_next = timer_reg;
		case (state_reg)
			bss_pkg::RB_IDLE: begin
				timer_next = 32'(SETTLE_CYCLES);
				state_next = bss_pkg::RB_SETTLE;
			end
			bss_pkg::RB_SETTLE: begin
				if (timer_reg <= 32'd1 && avgFull) begin
					timer_next = 32'(EXTRA_CYCLES);
					state_next = bss_pkg::RB_EXTRA;
				end else if (timer_reg > 32'd1) begin
					timer_next = timer_reg - 32'd1;
				end
			end
			bss_pkg::RB_EXTRA: begin
				if (timer_reg <= 32'd1)
					state_next = bss_pkg::RB_VALID;
				else
					timer_next = timer_reg - 32'd1;
			end
			bss_pkg::RB_VALID: begin
				state_next = bss_pkg::RB_VALID;
			end
			default: begin
				state_next = bss_pkg::RB_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= bss_pkg::RB_IDLE;
			timer_reg <= '0;
		end else begin
			state_reg <= state_next;
			timer_reg <= timer_next;
		end
	end

	assign readbackValid = (state_reg == bss_pkg::RB_VALID);
endmodule
`default_nettype wire

// *** core/bss_pkg.sv ***
package bss_pkg;
	localparam int WORD_W        = 16;
	localparam int AVG_LOG2      = 4;
	localparam int AVG_DEPTH     = 16;
	localparam int SUM_W         = WORD_W + AVG_LOG2;
	localparam int CLK_HZ        = 10_000_000;
	localparam int EXTRA_MS      = 320;
	localparam int EXTRA_CYCLES  = (CLK_HZ / 1000) * EXTRA_MS;
	localparam int SETTLE_CYCLES = 1000;
	localparam logic [WORD_W-1:0] ZERO_WORD = 16'h0000;

	typedef enum logic [1:0] {
		RB_IDLE   = 2'b00,
		RB_SETTLE = 2'b01,
		RB_EXTRA  = 2'b11,
		RB_VALID  = 2'b10
	} bss_rb_state_t;
endpackage

// *** tb/bss_core_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module bss_core_sva (
	// Watched
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        remoteReq,
	input wire logic        localReq,
	input wire logic        voltWr,
	input wire logic        currWr,
	input wire logic        outWr,
	input wire logic        outOnIn,
	input wire logic [15:0] setData,
	input wire logic        remoteMode,
	input wire logic [15:0] voltProg,
	input wire logic [15:0] currProg,
	input wire logic        outputOn,
	input wire logic        sampleValid,
	input wire logic [15:0] readback,
	input wire logic        readbackValid
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	stay_local_a: assert property (!remoteMode && !remoteReq |=> !remoteMode) else $error("went remote");
	go_local_a: assert property (localReq |=> !remoteMode) else $error("not local");
	volt_load_a: assert property (voltWr && remoteMode |=> voltProg == $past(setData)) else $error("volt");
	curr_load_a: assert property (currWr && remoteMode |=> currProg == $past(setData)) else $error("curr");
	out_load_a: assert property (outWr && remoteMode |=> outputOn == $past(outOnIn)) else $error("out");
	local_hold_a: assert property (!remoteMode |=> $stable({voltProg, currProg, outputOn})) else $error("hold");
	mean_hold_a: assert property (!sampleValid |=> $stable(readback)) else $error("mean");
	valid_stick_a: assert property (readbackValid |=> readbackValid) else $error("valid");
endmodule
bind bss_core bss_core_sva chk (.clk(clk), .rst_n(rst_n), .remoteReq(remoteReq),
	.localReq(localReq), .voltWr(voltWr), .currWr(currWr), .outWr(outWr),
	.outOnIn(outOnIn), .setData(setData), .remoteMode(remoteMode), .voltProg(voltProg),
	.currProg(currProg), .outputOn(outputOn), .sampleValid(sampleValid),
	.readback(readback), .readbackValid(readbackValid));
`default_nettype wire

// *** tb/bss_core_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; $display("ERROR %0t %h %h", $time, a, b); end end
module bss_core_test;
	logic        clk = 0;
	logic        rst_n = 0;
	logic        sampleValid = 0;
	logic [15:0] sample = '0;
	wire logic   remoteReq, localReq, voltWr, currWr, outWr, outOnIn;
	wire logic   remoteMode, outputOn, readbackValid;
	wire logic [15:0] setData, voltProg, currProg, readback;
	int          miscompares = 0;
	int          checked = 0;
	int          cycles = 0;
	always #50 clk = ~clk;
	bss_host host (.clk(clk), .remoteReq(remoteReq), .localReq(localReq), .voltWr(voltWr),
		.currWr(currWr), .outWr(outWr), .outOnIn(outOnIn), .setData(setData));
	bss_core #(.EXTRA_CYCLES(20), .SETTLE_CYCLES(5)) dut (.clk(clk), .rst_n(rst_n),
		.remoteReq(remoteReq), .localReq(localReq), .voltWr(voltWr), .currWr(currWr),
		.outWr(outWr), .outOnIn(outOnIn), .setData(setData), .remoteMode(remoteMode),
		.voltProg(voltProg), .currProg(currProg), .outputOn(outputOn),
		.sampleValid(sampleValid), .sample(sample), .readback(readback),
		.readbackValid(readbackValid));
	task automatic close_out;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			close_out();
		end
	end
	task automatic feed(input logic [15:0] s);
		@(posedge clk);
		{sampleValid, sample} <= {1'b1, s};
		@(posedge clk);
		{sampleValid, sample} <= {1'b0, ~s};
	endtask
	task automatic t_reset;
		`CHK(remoteMode, 1'b0)
		`CHK({voltProg, currProg, outputOn}, 33'h0_0000_0000)
		`CHK({readback, readbackValid}, 17'h0_0000)
	endtask
	task automatic t_prog;
		host.send(0, 16'h1234);
		#1 `CHK(voltProg, 16'h0000)
		host.send(3, 16'h0000);
		#1 `CHK(remoteMode, 1'b1)
		host.send(0, 16'h8001);
		#1 `CHK(voltProg, 16'h8001)
		host.send(1, 16'h7fff);
		#1 `CHK(currProg, 16'h7fff)
		host.send(2, 16'h0001);
		#1 `CHK(outputOn, 1'b1)
		host.send(4, 16'h0000);
		host.send(1, 16'h0002);
		#1 `CHK({remoteMode, currProg}, 17'h0_7fff)
	endtask
	task automatic t_avg;
		feed(16'hfffd);
		@(posedge clk);
		#1 `CHK(readback, 16'hffff)
		repeat (15) feed(16'hfffd);
		#1 `CHK(readbackValid, 1'b0)
		@(posedge clk);
		#1 `CHK(readback, 16'hfffd)
		repeat (19) @(posedge clk);
		#1 `CHK(readbackValid, 1'b0)
		@(posedge clk);
		#1 `CHK(readbackValid, 1'b1)
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		#1 t_reset();
		t_prog();
		t_avg();
		close_out();
	end
endmodule
`default_nettype wire

// *** tb/bss_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module bss_host (
	// Host bus
	input  wire logic        clk,
	output logic             remoteReq,
	output logic             localReq,
	output logic             voltWr,
	output logic             currWr,
	output logic             outWr,
	output logic             outOnIn,
	output logic      [15:0] setData
);
	initial {remoteReq, localReq, voltWr, currWr, outWr, outOnIn, setData} = '0;
	// One strobe for one edge, data inverted once released
	task automatic send(input logic [2:0] k, input logic [15:0] d);
		@(posedge clk);
		{localReq, remoteReq, outWr, currWr, voltWr} <= 5'h1 << k;
		{outOnIn, setData} <= {d[0], d};
		@(posedge clk);
		{localReq, remoteReq, outWr, currWr, voltWr} <= 5'h0;
		{outOnIn, setData} <= ~{d[0], d};
	endtask
endmodule
`default_nettype wire
